/* File: hw/imm_defines.svh */
`ifndef IMM_DEFINES_SVH
`define IMM_DEFINES_SVH

// Register indices; byte address is index * 4
`define IMM_IDX_GIC        8'h0b
`define IMM_IDX_PIF1       8'h0c
`define IMM_IDX_SBUF       8'h13
`define IMM_IDX_SCTL       8'h14
`define IMM_IDX_PCDIR      8'h87
`define IMM_IDX_PERIPHERAL_INTERRUPT_ENABLES_1       8'h8c
`define IMM_IDX_SADDR      8'h93
`define IMM_IDX_SSTAT      8'h94
`define IMM_IDX_MCTL       8'h95
`define IMM_IDX_ARB        8'h96

// Reset values
`define IMM_RST_ZERO       8'h00
`define IMM_RST_PCDIR      8'hff

// Field positions
`define IMM_IRQ_BIT        3
`define IMM_EN_BIT         5
`define IMM_P_BIT          4
`define IMM_S_BIT          3
`define IMM_SDA_DIR_BIT    4
`define IMM_SCL_DIR_BIT    3
`define IMM_MODE_MASTER    4'hb

// Timing
`define IMM_CLK_NS         4
`define IMM_SETTLE_NS      16
`define IMM_SETTLE_CYC     ((`IMM_SETTLE_NS + `IMM_CLK_NS - 1) / `IMM_CLK_NS)
`define IMM_ACK_BIT        4'h8
`define IMM_LAST_BIT       4'h9

`endif

/* File: hw/imm_pkg.sv */
package imm_pkg;

    typedef struct packed {
        logic scl;
        logic sda;
    } imm_lines_s;

    typedef enum logic [1:0] {
        IMM_PH_IDLE,
        IMM_PH_ADDR,
        IMM_PH_DATA
    } imm_phase_e;

    typedef logic [7:0] imm_byte_t;

endpackage

/* File: hw/imm_monitor.sv */
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "imm_defines.svh"
`default_nettype none

module imm_monitor
(
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_b_in,
    // APB slave
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [9:0]          paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic [31:0]              prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    // Two-wire bus
    input  wire imm_pkg::imm_lines_s lines_in,
    output imm_pkg::imm_lines_s      lines_out,
    output imm_pkg::imm_lines_s      lines_oe_b_out,
    // Status
    output logic                     bus_free_out,
    output logic                     irq_out
);
    import imm_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    imm_byte_t  gic_reg, pif1_reg, sbuf_reg, sctl_reg, pcdir_reg;
    imm_byte_t  peripheral_interrupt_enables_1_reg, saddr_reg, sstat_hi_reg;
    logic       start_reg, stop_reg, da_reg, rw_reg, bf_reg;
    logic       master_reg, lost_addr_reg, lost_data_reg;
    imm_byte_t  rdata_next;
    logic       hit, acc, wr, rd;
    logic [7:0] idx;

    assign idx = paddr_in[9:2];
    assign acc = psel_in && penable_in;
    assign wr  = acc && pwrite_in;
    assign rd  = acc && !pwrite_in;

    // ----------------------------------------
    // Line synchronisers
    // ----------------------------------------
    imm_lines_s s1_reg, s2_reg, s3_reg, lq_reg, lp_reg;
    logic       scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
            lq_reg <= '1;
            lp_reg <= '1;
        end
        else
        begin
            s1_reg <= lines_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg.scl == s3_reg.scl)
                lq_reg.scl <= s3_reg.scl;
            if (s2_reg.sda == s3_reg.sda)
                lq_reg.sda <= s3_reg.sda;
            lp_reg <= lq_reg;
        end
    end

    assign scl_rise  = lq_reg.scl && !lp_reg.scl;
    assign scl_fall  = !lq_reg.scl && lp_reg.scl;
    assign start_det = lq_reg.scl && lp_reg.scl && lp_reg.sda && !lq_reg.sda;
    assign stop_det  = lq_reg.scl && lp_reg.scl && !lp_reg.sda && lq_reg.sda;

    logic port_en, slave_en;
    assign port_en  = sctl_reg[`IMM_EN_BIT];
    assign slave_en = sctl_reg[3:0] != `IMM_MODE_MASTER;

    // ----------------------------------------
    // Start and stop flags
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in || !port_en)
        begin
            start_reg <= 1'b0;
            stop_reg  <= 1'b0;
        end
        else if (start_det)
        begin
            start_reg <= 1'b1;
            stop_reg  <= 1'b0;
        end
        else if (stop_det)
        begin
            start_reg <= 1'b0;
            stop_reg  <= 1'b1;
        end
    end

    assign bus_free_out = stop_reg || (!start_reg && !stop_reg);

    // ----------------------------------------
    // Bit and phase tracking
    // ----------------------------------------
    imm_phase_e phase_reg;
    logic [3:0] bit_reg;
    imm_byte_t  shift_reg;
    logic       addressed_reg, ack_reg, byte_done;

    assign byte_done = port_en && scl_fall && bit_reg == `IMM_LAST_BIT
                       && phase_reg != IMM_PH_IDLE;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in || !port_en || stop_det)
            phase_reg <= IMM_PH_IDLE;
        else if (start_det)
            phase_reg <= IMM_PH_ADDR;
        else if (byte_done)
            phase_reg <= IMM_PH_DATA;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in || start_det || !port_en)
            bit_reg <= 4'h0;
        else if (scl_rise && bit_reg != `IMM_LAST_BIT)
            bit_reg <= bit_reg + 4'h1;
        else if (scl_fall && bit_reg == `IMM_LAST_BIT)
            bit_reg <= 4'h0;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            shift_reg <= `IMM_RST_ZERO;
        else if (scl_rise && bit_reg < `IMM_ACK_BIT)
            shift_reg <= {shift_reg[6:0], lq_reg.sda};
    end

    // Slave side keeps listening even after arbitration loss
    logic addr_match;
    assign addr_match = shift_reg[7:1] == saddr_reg[7:1];

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in || start_det || stop_det || !port_en)
            addressed_reg <= 1'b0;
        else if (scl_fall && bit_reg == `IMM_ACK_BIT && phase_reg == IMM_PH_ADDR)
            addressed_reg <= slave_en && addr_match;
    end

    // Acknowledge for own address and written bytes, held over the ninth bit
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in || !port_en || start_det || stop_det)
            ack_reg <= 1'b0;
        else if (scl_fall && bit_reg == `IMM_ACK_BIT)
        begin
            if (phase_reg == IMM_PH_ADDR)
                ack_reg <= slave_en && addr_match;
            else
                ack_reg <= addressed_reg && !rw_reg;
        end
        else if (scl_fall)
            ack_reg <= 1'b0;
    end

    // ----------------------------------------
    // Arbitration check
    // ----------------------------------------
    // Waiting for a settled high clock avoids blaming normal data edges
    logic [7:0] settle_reg;
    logic       arb_check, arb_lost;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in || !lq_reg.scl)
            settle_reg <= 8'h00;
        else if (settle_reg != 8'(`IMM_SETTLE_CYC))
            settle_reg <= settle_reg + 8'h01;
    end

    assign arb_check = settle_reg == 8'(`IMM_SETTLE_CYC - 1);
    assign arb_lost  = arb_check && master_reg && port_en
                       && pcdir_reg[`IMM_SDA_DIR_BIT] && !lq_reg.sda
                       && !ack_reg && bit_reg != `IMM_LAST_BIT
                       && phase_reg != IMM_PH_IDLE;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            master_reg <= 1'b0;
        else if (arb_lost)
            master_reg <= 1'b0;
        else if (wr && idx == `IMM_IDX_MCTL)
            master_reg <= pwdata_in[0];
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            lost_addr_reg <= 1'b0;
            lost_data_reg <= 1'b0;
        end
        else
        begin
            lost_addr_reg <= (arb_lost && phase_reg == IMM_PH_ADDR)
                             || (lost_addr_reg && !(wr && idx == `IMM_IDX_ARB && pwdata_in[0]));
            lost_data_reg <= (arb_lost && phase_reg == IMM_PH_DATA)
                             || (lost_data_reg && !(wr && idx == `IMM_IDX_ARB && pwdata_in[1]));
        end
    end

    // ----------------------------------------
    // Direction register and pins
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            pcdir_reg <= `IMM_RST_PCDIR;
        else
        begin
            if (wr && idx == `IMM_IDX_PCDIR)
                pcdir_reg <= pwdata_in[7:0];
            if (arb_lost)
            begin
                pcdir_reg[`IMM_SDA_DIR_BIT] <= 1'b1;
                pcdir_reg[`IMM_SCL_DIR_BIT] <= 1'b1;
            end
        end
    end

    // Only ever drive low; a one is a released line
    assign lines_out          = '0;
    assign lines_oe_b_out.scl = pcdir_reg[`IMM_SCL_DIR_BIT];
    assign lines_oe_b_out.sda = pcdir_reg[`IMM_SDA_DIR_BIT] && !ack_reg;

    // ----------------------------------------
    // Buffer, status and interrupt flags
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            sbuf_reg <= `IMM_RST_ZERO;
            bf_reg   <= 1'b0;
            da_reg   <= 1'b0;
            rw_reg   <= 1'b0;
        end
        else if (scl_fall && bit_reg == `IMM_ACK_BIT && phase_reg != IMM_PH_IDLE)
        begin
            sbuf_reg <= shift_reg;
            bf_reg   <= 1'b1;
            da_reg   <= phase_reg == IMM_PH_DATA;
            if (phase_reg == IMM_PH_ADDR)
                rw_reg <= shift_reg[0];
        end
        else if (wr && idx == `IMM_IDX_SBUF)
            sbuf_reg <= pwdata_in[7:0];
        else if (rd && idx == `IMM_IDX_SBUF)
            bf_reg <= 1'b0;
    end

    // Hardware set wins over a software write-one clear
    logic irq_set;
    assign irq_set = port_en && (start_det || stop_det || byte_done);

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            pif1_reg <= `IMM_RST_ZERO;
        else
        begin
            if (wr && idx == `IMM_IDX_PIF1)
                pif1_reg <= pif1_reg & ~pwdata_in[7:0];
            if (irq_set)
                pif1_reg[`IMM_IRQ_BIT] <= 1'b1;
        end
    end

    // Level output; enabling while busy still fires at the stop
    assign irq_out = |(pif1_reg & peripheral_interrupt_enables_1_reg);

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            gic_reg      <= `IMM_RST_ZERO;
            sctl_reg     <= `IMM_RST_ZERO;
            peripheral_interrupt_enables_1_reg     <= `IMM_RST_ZERO;
            saddr_reg    <= `IMM_RST_ZERO;
            sstat_hi_reg <= `IMM_RST_ZERO;
        end
        else if (wr)
        begin
            case (idx)
                `IMM_IDX_GIC:   gic_reg      <= pwdata_in[7:0];
                `IMM_IDX_SCTL:  sctl_reg     <= pwdata_in[7:0];
                `IMM_IDX_PERIPHERAL_INTERRUPT_ENABLES_1:  peripheral_interrupt_enables_1_reg     <= pwdata_in[7:0];
                `IMM_IDX_SADDR: saddr_reg    <= pwdata_in[7:0];
                `IMM_IDX_SSTAT: sstat_hi_reg <= {pwdata_in[7:6], 6'h00};
                default:        gic_reg      <= gic_reg;
            endcase
        end
    end

    // ----------------------------------------
    // APB read path
    // ----------------------------------------
    always_comb
    begin
        rdata_next = `IMM_RST_ZERO;
        hit        = 1'b1;
        case (idx)
            `IMM_IDX_GIC:   rdata_next = gic_reg;
            `IMM_IDX_PIF1:  rdata_next = pif1_reg;
            `IMM_IDX_SBUF:  rdata_next = sbuf_reg;
            `IMM_IDX_SCTL:  rdata_next = sctl_reg;
            `IMM_IDX_PCDIR: rdata_next = pcdir_reg;
            `IMM_IDX_PERIPHERAL_INTERRUPT_ENABLES_1:  rdata_next = peripheral_interrupt_enables_1_reg;
            `IMM_IDX_SADDR: rdata_next = saddr_reg;
            `IMM_IDX_SSTAT: rdata_next = {sstat_hi_reg[7:6], da_reg, stop_reg,
                                          start_reg, rw_reg, 1'b0, bf_reg};
            `IMM_IDX_MCTL:  rdata_next = {7'h00, master_reg};
            `IMM_IDX_ARB:   rdata_next = {6'h00, lost_data_reg, lost_addr_reg};
            default:        hit        = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            prdata_out <= 32'h0000_0000;
        else if (psel_in && !penable_in)
            prdata_out <= {24'h00_0000, rdata_next};
    end

    assign pready_out  = 1'b1;
    assign pslverr_out = acc && !hit;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence seq_start_seen;
        port_en && start_det;
    endsequence

    sequence seq_flags_start;
        start_reg && !stop_reg;
    endsequence

    a_start_flag: assert property (seq_start_seen |=> seq_flags_start)
        else $error("start flag not set after start");
    a_stop_flag: assert property (port_en && stop_det && !start_det
                                  |=> stop_reg && !start_reg)
        else $error("stop flag not set after stop");
    a_disable_clear: assert property (!port_en |=> !start_reg && !stop_reg)
        else $error("flags survive disabled port");
    a_bus_free: assert property (bus_free_out == (stop_reg || !start_reg))
        else $error("bus free wrong");
    a_event_irq: assert property (irq_set |=> pif1_reg[`IMM_IRQ_BIT])
        else $error("event did not set interrupt flag");
    a_irq_level: assert property (peripheral_interrupt_enables_1_reg[`IMM_IRQ_BIT] && pif1_reg[`IMM_IRQ_BIT]
                                  |-> irq_out)
        else $error("enabled flag without interrupt");
    a_arb_release: assert property (arb_lost |=> lines_oe_b_out.scl
                                    && pcdir_reg[`IMM_SDA_DIR_BIT] && !master_reg)
        else $error("lines not released after loss");
    a_arb_window: assert property (arb_lost |-> lq_reg.scl
                                   && $past(lq_reg.scl, 2))
        else $error("loss judged on unsettled clock");
    a_loss_phase: assert property (arb_lost && phase_reg == IMM_PH_DATA
                                   |=> lost_data_reg [*2])
        else $error("data phase loss not held");
    a_ack_drive: assert property (scl_fall && bit_reg == `IMM_ACK_BIT && port_en
                                  && phase_reg == IMM_PH_ADDR && slave_en && addr_match
                                  && !start_det && !stop_det
                                  |=> !lines_oe_b_out.sda)
        else $error("own address not acknowledged");

endmodule

`default_nettype wire

/* File: test/imm_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Other bus master, released lines float high
// ------------------------------------------------------------
module imm_peer
(
    // Clock
    input  wire logic clk_in,
    // Bus
    input  wire logic sda_in,
    output logic      scl_dn_out,
    output logic      sda_dn_out
);
    // Quarter of the 80 ns link period; clock stands high between frames
    localparam int Q = 5;

    initial
    begin
        scl_dn_out = 1'b0;
        sda_dn_out = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic start();
        sda_dn_out <= 1'b1;
        hold(2 * Q);
        scl_dn_out <= 1'b1;
        hold(Q);
    endtask

    // Eight bits msb first, then the ninth bit released for the ack
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--)
        begin
            sda_dn_out <= (i >= 0) ? ~b[i] : 1'b0;
            hold(Q);
            scl_dn_out <= 1'b0;
            hold(Q);
            ack = sda_in;
            hold(Q);
            scl_dn_out <= 1'b1;
            hold(Q);
        end
    endtask

    task automatic stop();
        sda_dn_out <= 1'b1;
        hold(Q);
        scl_dn_out <= 1'b0;
        hold(2 * Q);
        sda_dn_out <= 1'b0;
        hold(2 * Q);
    endtask
endmodule
`default_nettype wire

/* File: test/i2c_multi_master_bus_monitor_bench.sv */
`timescale 1ns/1ps
`include "imm_defines.svh"
`default_nettype none
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module i2c_multi_master_bus_monitor_bench;
    import imm_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, bus_free, irq;
    logic        scl_dn, sda_dn, ack, err;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    imm_lines_s  lines_in, lines_out, lines_oe_b;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    // Wired-and with pull-ups
    assign lines_in.scl = ~scl_dn & (lines_oe_b.scl | lines_out.scl);
    assign lines_in.sda = ~sda_dn & (lines_oe_b.sda | lines_out.sda);

    always #2 clk_in = ~clk_in;

    imm_monitor dut_u
    (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .lines_in(lines_in), .lines_out(lines_out),
        .lines_oe_b_out(lines_oe_b), .bus_free_out(bus_free), .irq_out(irq)
    );

    imm_peer peer_u
    (
        .clk_in(clk_in), .sda_in(lines_in.sda),
        .scl_dn_out(scl_dn), .sda_dn_out(sda_dn)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        // Only the watchdog may end a wait for the answer
        while (pready !== 1'b1)
            @(posedge clk_in);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask

    // Loss is provoked only once the first bit has ended
    task automatic lose(input logic [7:0] b);
        fork
            peer_u.send_byte(b, ack);
            begin
                @(negedge lines_in.scl);
                repeat (6) @(posedge clk_in);
                apb(1'b1, `IMM_IDX_MCTL, 32'h1);
            end
        join
    endtask

    task automatic conclude();
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge clk_in);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        rdchk(`IMM_IDX_PIF1, 32'h0);
        rdchk(`IMM_IDX_SCTL, 32'h0);
        rdchk(`IMM_IDX_PCDIR, 32'hff);
        rdchk(`IMM_IDX_PERIPHERAL_INTERRUPT_ENABLES_1, 32'h0);
        rdchk(`IMM_IDX_SADDR, 32'h0);
        rdchk(`IMM_IDX_SSTAT, 32'h0);
        chk({31'h0, bus_free}, 32'h1);
        apb(1'b0, 8'h01, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Disabled port ignores the bus
        peer_u.start();
        rdchk(`IMM_IDX_SSTAT, 32'h0);
        peer_u.stop();
        apb(1'b1, `IMM_IDX_PCDIR, 32'h08);
        chk({28'h0, lines_oe_b, lines_out}, 32'h8);
        apb(1'b1, `IMM_IDX_PCDIR, 32'hff);
        chk({28'h0, lines_oe_b, lines_out}, 32'hc);
        apb(1'b1, `IMM_IDX_SADDR, 32'h84);
        apb(1'b1, `IMM_IDX_SSTAT, 32'h0);
        apb(1'b1, `IMM_IDX_SCTL, 32'h26);
        peer_u.start();
        repeat (8) @(posedge clk_in);
        rdchk(`IMM_IDX_SSTAT, 32'h08);
        chk({31'h0, bus_free}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `IMM_IDX_PERIPHERAL_INTERRUPT_ENABLES_1, 32'h08);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `IMM_IDX_PIF1, 32'h08);
        chk({31'h0, irq}, 32'h0);
        lose(8'h84);
        chk({31'h0, ack}, 32'h0);
        rdchk(`IMM_IDX_MCTL, 32'h0);
        rdchk(`IMM_IDX_ARB, 32'h1);
        rdchk(`IMM_IDX_PCDIR, 32'hff);
        rdchk(`IMM_IDX_PIF1, 32'h08);
        apb(1'b1, `IMM_IDX_ARB, 32'h3);
        apb(1'b1, `IMM_IDX_PIF1, 32'h08);
        lose(8'h55);
        chk({31'h0, ack}, 32'h0);
        rdchk(`IMM_IDX_ARB, 32'h2);
        rdchk(`IMM_IDX_MCTL, 32'h0);
        apb(1'b1, `IMM_IDX_PIF1, 32'h08);
        peer_u.stop();
        repeat (8) @(posedge clk_in);
        apb(1'b0, `IMM_IDX_SSTAT, 32'h0);
        chk(rd & 32'h18, 32'h10);
        chk({30'h0, bus_free, irq}, 32'h3);
        apb(1'b1, `IMM_IDX_PERIPHERAL_INTERRUPT_ENABLES_1, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Master-only mode: own address goes unanswered
        apb(1'b1, `IMM_IDX_SCTL, 32'h2b);
        peer_u.start();
        peer_u.send_byte(8'h84, ack);
        chk({31'h0, ack}, 32'h1);
        peer_u.stop();
        apb(1'b1, `IMM_IDX_SCTL, 32'h06);
        apb(1'b0, `IMM_IDX_SSTAT, 32'h0);
        chk(rd & 32'h18, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
